// File: src/sbsr_event_summary.v
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Event set summary: OR of event AND enable
// ****************************************
module sbsr_event_summary #(
  parameter WIDTH = 16
) (
  input  wire [WIDTH-1:0] event_bits,  // Latched event register
  input  wire [WIDTH-1:0] enable_bits, // Event enable register
  output wire             summary      // Summary message
);
  wire [WIDTH-1:0] masked;
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_and
      assign masked[i] = event_bits[i] & enable_bits[i];
    end
  endgenerate
  assign summary = |masked;
endmodule
`default_nettype wire

// File: src/sbsr_param_decode.v
`timescale 1ns/100ps
`default_nettype none
`include "sbsr_regs.vh"
// ****************************************
// Enable parameter radix decoder
// ****************************************
// Digits arrive as numeric values, most significant first; the
// radix selects the weight so all forms give the same byte.
module sbsr_param_decode (
  input  wire [1:0] radix,    // Parameter format code
  input  wire [7:0] acc,      // Value so far
  input  wire [3:0] digit,    // Next digit value
  output reg  [7:0] acc_next, // Value after digit
  output reg        digit_ok  // Digit legal for radix
);
  reg [11:0] wide;
  always @* begin
    wide     = 12'h000;
    digit_ok = 1'b0;
    case (radix)
      `SBSR_RADIX_BIN: begin
        wide     = {3'h0, acc, 1'b0} + {8'h00, digit};
        digit_ok = (digit < 4'h2);
      end
      `SBSR_RADIX_HEX: begin
        wide     = {acc, 4'h0} + {8'h00, digit};
        digit_ok = 1'b1;
      end
      `SBSR_RADIX_OCT: begin
        wide     = {1'b0, acc, 3'h0} + {8'h00, digit};
        digit_ok = (digit < 4'h8);
      end
      default: begin
        wide     = {1'b0, acc, 3'h0} + {3'h0, acc, 1'b0} + {8'h00, digit};
        digit_ok = (digit < 4'hA);
      end
    endcase
    // Values beyond one byte are refused
    if (wide[11:8] != 4'h0) begin
      digit_ok = 1'b0;
    end
    acc_next = wide[7:0];
  end
endmodule
`default_nettype wire

// File: src/sbsr_regs.vh
`ifndef SBSR_REGS_VH
`define SBSR_REGS_VH
// ****************************************
// Status byte bit positions
// ****************************************
`define SBSR_BIT_MEAS     0
`define SBSR_BIT_UNUSED   1
`define SBSR_BIT_ERRQ     2
`define SBSR_BIT_QUES     3
`define SBSR_BIT_MSGQ     4
`define SBSR_BIT_STDEV    5
`define SBSR_BIT_RQS      6
`define SBSR_BIT_OPER     7
// ****************************************
// Reset values and masks
// ****************************************
`define SBSR_SRE_RESET    8'h00
`define SBSR_SRE_USED     8'hBD
`define SBSR_BYTE_ZERO    8'h00
`define SBSR_EV_ZERO      16'h0000
// ****************************************
// Enable parameter radix codes
// ****************************************
`define SBSR_RADIX_BIN    2'h0
`define SBSR_RADIX_HEX    2'h1
`define SBSR_RADIX_OCT    2'h2
`define SBSR_RADIX_DEC    2'h3
`endif

// File: src/sbsr_status_byte.v
`timescale 1ns/100ps
`default_nettype none
`include "sbsr_regs.vh"
// Summary of operation
// - Summary bits 0,2,3,4,5,7 follow their summary inputs unlatched.
// - Bit 0 shows the measurement set summary.
// - Bit 2 set while the error queue holds a message.
// - Bit 3 shows the questionable set summary.
// - Bit 4 set while a response waits in the output queue.
// - Bit 5 shows the standard event set summary.
// - Bit 7 shows the operation set summary.
// - Master summary is OR of summaries ANDed with enables.
// - Bit 6 is request flag on poll, master summary on query.
// - Eight-bit enable register, written by command, cleared at power-up.
// - Clear-status and preset leave the enable register alone.
// - Rising enabled summary sets request flag and asserts service request.
// - Serial poll clears request flag; later rise requests again.
// - Poll leaves master summary; it drops when enabled summaries drop.
// - Controller polls with enable, one byte, disable; device returns byte.
// - Enable query returns enable register; status query returns status byte.
// - Reading the standard event register clears it and its summary.
// - Enable parameter accepted in binary, hex, octal or decimal.
// - Each set summary is OR of event bits ANDed with enables.
module sbsr_status_byte #(
  parameter EV_WIDTH = 16
) (
  input  wire                clock,          // 125 MHz clock
  input  wire                nrst,           // Async reset, active low
  input  wire [EV_WIDTH-1:0] std_event,      // Standard event register
  input  wire [EV_WIDTH-1:0] std_enable,     // Standard event enable
  input  wire [EV_WIDTH-1:0] oper_event,     // Operation event register
  input  wire [EV_WIDTH-1:0] oper_enable,    // Operation event enable
  input  wire [EV_WIDTH-1:0] meas_event,     // Measurement event register
  input  wire [EV_WIDTH-1:0] meas_enable,    // Measurement event enable
  input  wire [EV_WIDTH-1:0] ques_event,     // Questionable event register
  input  wire [EV_WIDTH-1:0] ques_enable,    // Questionable event enable
  input  wire                error_queue_nonempty, // Error queue has entry
  input  wire                output_message_ready, // Output queue has entry
  input  wire                std_event_read, // Standard event register read
  input  wire                sre_write,      // Enable command, value ready
  input  wire [7:0]          sre_wdata,      // Enable value, binary
  input  wire                param_start,    // Begin text parameter
  input  wire [1:0]          param_radix,    // Text parameter format
  input  wire                param_digit_vld,// Parameter digit strobe
  input  wire [3:0]          param_digit,    // Parameter digit value
  input  wire                param_end,      // Commit text parameter
  input  wire                clear_status,   // Clear-status command
  input  wire                status_preset,  // Status preset command
  input  wire                sre_query,      // Enable register query
  input  wire                stb_query,      // Status byte query
  input  wire                spoll_active,   // Serial poll enabled
  input  wire                spoll_read,     // Poll byte taken, one cycle
  output reg  [7:0]          resp_data_q,    // Query response byte
  output reg                 resp_valid_q,   // Query response strobe
  output reg  [7:0]          spoll_byte_q,   // Serial poll byte
  output reg  [7:0]          status_byte_q,  // Status byte, master summary
  output reg  [7:0]          sre_q,          // Enable register copy
  output reg                 srq_q,          // Service request line
  output reg                 std_clear_q,    // Clear standard event reg
  output reg                 param_err_q     // Bad parameter digit
);
  // ****************************************
  // Set summaries
  // ****************************************
  wire meas_sum;
  wire ques_sum;
  wire oper_sum;
  wire std_raw;
  wire std_sum;
  sbsr_event_summary #(.WIDTH(EV_WIDTH)) u_meas (
    .event_bits  (meas_event),
    .enable_bits (meas_enable),
    .summary     (meas_sum)
  );
  sbsr_event_summary #(.WIDTH(EV_WIDTH)) u_ques (
    .event_bits  (ques_event),
    .enable_bits (ques_enable),
    .summary     (ques_sum)
  );
  sbsr_event_summary #(.WIDTH(EV_WIDTH)) u_oper (
    .event_bits  (oper_event),
    .enable_bits (oper_enable),
    .summary     (oper_sum)
  );
  sbsr_event_summary #(.WIDTH(EV_WIDTH)) u_std (
    .event_bits  (std_event),
    .enable_bits (std_enable),
    .summary     (std_raw)
  );
  // Masked during the read so the bit drops before the clear lands
  assign std_sum = std_raw & ~std_event_read & ~std_clear_q;

  // ****************************************
  // Status byte, combinational
  // ****************************************
  reg [7:0] summ;
  always @* begin
    summ                   = `SBSR_BYTE_ZERO;
    summ[`SBSR_BIT_MEAS]   = meas_sum;
    summ[`SBSR_BIT_UNUSED] = 1'b0;
    summ[`SBSR_BIT_ERRQ]   = error_queue_nonempty;
    summ[`SBSR_BIT_QUES]   = ques_sum;
    summ[`SBSR_BIT_MSGQ]   = output_message_ready;
    summ[`SBSR_BIT_STDEV]  = std_sum;
    summ[`SBSR_BIT_OPER]   = oper_sum;
  end

  wire [7:0] enabled_summ;
  wire       master_summary;
  assign enabled_summ   = summ & sre_q & `SBSR_SRE_USED;
  assign master_summary = |enabled_summ;

  // ****************************************
  // Request flag on rising enabled summaries
  // ****************************************
  reg  [7:0] enabled_prev_q;
  reg        request_service_flag_q;
  wire       any_rise;
  assign any_rise = |(enabled_summ & ~enabled_prev_q);

  // ****************************************
  // Text parameter assembly
  // ****************************************
  reg  [7:0] param_acc_q;
  reg        param_bad_q;
  wire [7:0] acc_next;
  wire       digit_ok;
  sbsr_param_decode u_dec (
    .radix    (param_radix),
    .acc      (param_acc_q),
    .digit    (param_digit),
    .acc_next (acc_next),
    .digit_ok (digit_ok)
  );

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      param_acc_q <= `SBSR_BYTE_ZERO;
      param_bad_q <= 1'b0;
      param_err_q <= 1'b0;
    end else begin
      param_err_q <= 1'b0;
      if (param_start) begin
        param_acc_q <= `SBSR_BYTE_ZERO;
        param_bad_q <= 1'b0;
      end else if (param_digit_vld) begin
        if (digit_ok) begin
          param_acc_q <= acc_next;
        end else begin
          param_bad_q <= 1'b1;
        end
      end
      if (param_end) begin
        param_err_q <= param_bad_q;
      end
    end
  end

  // ****************************************
  // Enable register
  // ****************************************
  // Clear-status and preset have no path here on purpose
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sre_q <= `SBSR_SRE_RESET;
    end else if (sre_write) begin
      sre_q <= sre_wdata;
    end else if (param_end && !param_bad_q) begin
      sre_q <= param_acc_q;
    end
  end

  // ****************************************
  // Request flag, service request, poll byte
  // ****************************************
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      enabled_prev_q         <= `SBSR_BYTE_ZERO;
      request_service_flag_q <= 1'b0;
      srq_q                  <= 1'b0;
      spoll_byte_q           <= `SBSR_BYTE_ZERO;
      status_byte_q          <= `SBSR_BYTE_ZERO;
    end else begin
      enabled_prev_q <= enabled_summ;
      // A rise in the poll cycle wins so no request is lost
      if (any_rise) begin
        request_service_flag_q <= 1'b1;
        srq_q                  <= 1'b1;
      end else if (spoll_read) begin
        request_service_flag_q <= 1'b0;
        srq_q                  <= 1'b0;
      end
      // Byte held still while the controller is reading it
      if (!spoll_active) begin
        spoll_byte_q <= summ;
        spoll_byte_q[`SBSR_BIT_RQS] <= request_service_flag_q | any_rise;
      end
      status_byte_q <= summ;
      status_byte_q[`SBSR_BIT_RQS] <= master_summary;
    end
  end

  // ****************************************
  // Query responses and event clear
  // ****************************************
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      resp_data_q  <= `SBSR_BYTE_ZERO;
      resp_valid_q <= 1'b0;
      std_clear_q  <= 1'b0;
    end else begin
      resp_valid_q <= sre_query | stb_query;
      std_clear_q  <= std_event_read;
      if (stb_query) begin
        resp_data_q <= summ;
        resp_data_q[`SBSR_BIT_RQS] <= master_summary;
      end else if (sre_query) begin
        resp_data_q <= sre_q;
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/sbsr_bus_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
module sbsr_bus_ctrl (
  input  wire logic       clock,        // Clock
  input  wire logic       go,           // Start poll
  input  wire logic [3:0] wait_n,       // Read delay
  input  wire logic [7:0] poll_byte,    // Device byte
  output var  logic       spoll_active, // Poll window
  output var  logic       spoll_read,   // Byte taken
  output var  logic       done,         // Poll over
  output var  logic [7:0] got           // Byte read
);
  logic [4:0] cnt;
  initial {spoll_active, spoll_read, done, got, cnt} = '0;
  // Falling edge, so the device samples settled levels
  always @(negedge clock) begin
    spoll_read <= 1'b0;
    done <= 1'b0;
    if (go && !spoll_active && !done) begin
      spoll_active <= 1'b1;
      cnt <= {1'b0, wait_n} + 5'h02;
    end else if (spoll_active) begin
      cnt <= cnt - 5'h01;
      if (cnt == 5'h02) begin
        got <= poll_byte;
        spoll_read <= 1'b1;
      end
      if (cnt == 5'h01) begin
        spoll_active <= 1'b0;
        done <= 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// File: testbench/sbsr_status_byte_assertions.sv
`timescale 1ns/100ps
`default_nettype none
module sbsr_checker (
  input wire logic       clock,                // Clock
  input wire logic       nrst,                 // Reset
  input wire logic       error_queue_nonempty, // Error queue
  input wire logic       std_event_read,       // Std read
  input wire logic       sre_write,            // Enable write
  input wire logic [7:0] sre_wdata,            // Enable value
  input wire logic       stb_query,            // Byte query
  input wire logic       spoll_active,         // Poll window
  input wire logic       spoll_read,           // Poll taken
  input wire logic [7:0] resp_data_q,          // Answer
  input wire logic       resp_valid_q,         // Answer strobe
  input wire logic [7:0] spoll_byte_q,         // Poll byte
  input wire logic [7:0] status_byte_q,        // Status byte
  input wire logic [7:0] sre_q,                // Enable reg
  input wire logic       srq_q,                // Request line
  input wire logic       std_clear_q           // Std clear
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!nrst);
  sre_load_a: assert property (sre_write |=> sre_q == $past(sre_wdata)) else $error("enable load");
  bit1_zero_a: assert property (!status_byte_q[1] && !spoll_byte_q[1]) else $error("bit one set");
  query_ans_a: assert property (stb_query |=> resp_valid_q && resp_data_q == status_byte_q) else $error("query");
  errq_bit_a: assert property (status_byte_q[2] == $past(error_queue_nonempty)) else $error("error bit");
  srq_set_a: assert property ($rose(error_queue_nonempty) && sre_q[2] && !sre_write |=>
    srq_q && status_byte_q[6]) else $error("no request");
  // No rise in the poll cycle: enables steady and the summary byte unchanged one cycle on
  poll_clr_a: assert property (spoll_read && $stable(sre_q) ##1 $stable(status_byte_q) |-> !srq_q)
    else $error("poll clear");
  mss_keep_a: assert property (spoll_read && error_queue_nonempty && sre_q[2] && !sre_write |=> status_byte_q[6])
    else $error("summary lost");
  std_clr_a: assert property (std_event_read |=> std_clear_q && !status_byte_q[5]) else $error("std clear");
  poll_hold_a: assert property (spoll_active && $past(spoll_active) |-> $stable(spoll_byte_q))
    else $error("poll byte");
  cover property (srq_q && spoll_read);
  cover property (resp_valid_q);
  cover property (std_clear_q);
endmodule
bind sbsr_status_byte sbsr_checker chk_u (.*);
`default_nettype wire

// File: testbench/sbsr_testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
  logic        clock, nrst, error_queue_nonempty, output_message_ready, std_event_read, sre_write;
  logic        param_start, param_digit_vld, param_end, clear_status, status_preset, sre_query;
  logic        stb_query, spoll_active, spoll_read, resp_valid_q, srq_q, std_clear_q, param_err_q, go, done;
  logic [15:0] std_event, std_enable, oper_event, oper_enable, meas_event, meas_enable, ques_event, ques_enable;
  logic [7:0]  sre_wdata, resp_data_q, spoll_byte_q, status_byte_q, sre_q, got;
  logic [3:0]  param_digit, wait_n;
  logic [1:0]  param_radix;
  int          num_errors, num_checks;
  sbsr_status_byte #(.EV_WIDTH(16)) dut_u (.*);
  sbsr_bus_ctrl ctl_u (.clock, .go, .wait_n, .poll_byte(spoll_byte_q), .spoll_active, .spoll_read, .done, .got);
  always #4 clock = ~clock;
  task tick; @(negedge clock); endtask
  task chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, g, e);
    end
  endtask
  task complete_run;
    if (num_errors == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  task set_sum(input logic [7:0] s);
    {meas_event, ques_event} = {15'h0000, s[0], 15'h0000, s[3]};
    {std_event, oper_event} = {15'h0000, s[5], 15'h0000, s[7]};
    {error_queue_nonempty, output_message_ready} = {s[2], s[4]};
  endtask
  task qry(input logic sel, input logic [7:0] e);
    {sre_query, stb_query} = {sel, !sel};
    tick;
    {sre_query, stb_query} = 2'h0;
    chk({7'h00, resp_valid_q}, 8'h01);
    chk(resp_data_q, e);
    tick;
  endtask
  task wr_sre(input logic [7:0] v);
    {sre_write, sre_wdata} = {1'b1, v};
    tick;
    sre_write = 1'b0;
    tick;
  endtask
  task poll(input logic [3:0] w, input logic [7:0] e);
    {go, wait_n} = {1'b1, w};
    for (int k = 0; k < 40 && !done; k++) @(posedge clock);
    chk({7'h00, done}, 8'h01);
    chk(got, e);
    tick;
    go = 1'b0;
  endtask
  task pdo(input logic [1:0] r, input logic [23:0] d, input int n);
    {param_radix, param_start} = {r, 1'b1};
    tick;
    param_start = 1'b0;
    for (int k = n - 1; k >= 0; k--) begin
      {param_digit_vld, param_digit} = {1'b1, d[4*k +: 4]};
      tick;
    end
    {param_digit_vld, param_end} = 2'h1;
    tick;
    param_end = 1'b0;
  endtask
  task t_bits;
    for (int i = 0; i < 8; i++) begin
      set_sum(8'h01 << i);
      tick;
      chk(status_byte_q, 8'h01 << i & 8'hBD);
    end
    set_sum(8'hFF);
    meas_enable = 16'h0000;
    tick;
    chk(status_byte_q, 8'hBC);
    qry(1'b0, 8'hBC);
    meas_enable = 16'h0001;
    set_sum(8'h00);
  endtask
  task t_sre;
    wr_sre(8'hFF);
    {clear_status, status_preset} = 2'h3;
    tick;
    {clear_status, status_preset} = 2'h0;
    tick;
    chk(sre_q, 8'hFF);
    qry(1'b1, 8'hFF);
  endtask
  task t_param;
    logic [23:0] dg [4];
    dg = '{24'h101100, 24'h00002C, 24'h000054, 24'h000044};
    for (int r = 0; r < 4; r++) begin
      wr_sre(8'h00);
      pdo(r[1:0], dg[r], r == 0 ? 6 : 2);
      chk(sre_q, 8'h2C);
    end
    pdo(2'h2, 24'h000078, 2);
    chk({7'h00, param_err_q}, 8'h01);
    chk(sre_q, 8'h2C);
  endtask
  task t_srq;
    wr_sre(8'h04);
    set_sum(8'h04);
    tick;
    chk({7'h00, srq_q}, 8'h01);
    poll(4'h0, 8'h44);
    chk({7'h00, srq_q}, 8'h00);
    qry(1'b0, 8'h44);
    poll(4'h3, 8'h04);
    set_sum(8'h00);
    tick;
    set_sum(8'h04);
    tick;
    chk({7'h00, srq_q}, 8'h01);
    poll(4'h1, 8'h44);
    set_sum(8'h20);
    tick;
    // Bit five must drop in the read cycle, before the clear lands
    std_event_read = 1'b1;
    tick;
    std_event_read = 1'b0;
    chk({std_clear_q, status_byte_q[6:0]}, 8'h80);
  endtask
  initial begin
    {clock, nrst, error_queue_nonempty, output_message_ready, std_event_read, sre_write, go} = '0;
    {param_start, param_digit_vld, param_end, clear_status, status_preset, sre_query, stb_query} = '0;
    {sre_wdata, param_digit, wait_n, param_radix, std_event, oper_event, meas_event, ques_event} = '0;
    {std_enable, oper_enable, meas_enable, ques_enable} = {4{16'h0001}};
    {num_errors, num_checks} = '0;
    repeat (12) @(posedge clock);
    tick;
    nrst = 1'b1;
    tick;
    chk(sre_q, 8'h00);
    t_bits;
    t_sre;
    t_param;
    t_srq;
    complete_run;
  end
  initial begin
    #20000;
    num_errors++;
    complete_run;
  end
endmodule
`default_nettype wire
